// ### logic/sar_defs.svh
// Constants for the serial converter readout block
`ifndef SAR_DEFS_SVH
`define SAR_DEFS_SVH

// --------------------------------------------------------------
// Result word layout
// --------------------------------------------------------------
`define SAR_RES_BITS 14
`define SAR_SUB_BITS 2
`define SAR_WORD_BITS 16
`define SAR_LEAD_ZEROS 8
`define SAR_TRIAL_MSB 16'h8000
`define SAR_WORD_RST 16'h0000

// --------------------------------------------------------------
// Falling-edge numbers within a frame
// --------------------------------------------------------------
`define SAR_SAMPLE_EDGE 5'h06
`define SAR_FIRST_STEP 5'h07
`define SAR_LAST_STEP 5'h16
`define SAR_FIRST_OUT 5'h08
`define SAR_LAST_OUT 5'h17
`define SAR_FRAME_EDGES 5'h18

// --------------------------------------------------------------
// Timing
// --------------------------------------------------------------
`define SAR_CLK_NS 8
`define SAR_FSCLK_MAX_KHZ 4800
`define SAR_TCP_NS 208
`define SAR_TACQ_NS 1100
`define SAR_TCSW_NS 50
`define SAR_ACQ_CYC ((`SAR_TACQ_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`define SAR_CSW_CYC ((`SAR_TCSW_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`define SAR_TCP_CYC ((`SAR_TCP_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)

// --------------------------------------------------------------
// Synchroniser reset: chip select idles high
// --------------------------------------------------------------
`define SAR_SYNC_RST 4'h1

`endif

// ### logic/sar_pkg.sv
// Types for the serial converter readout block
package sar_pkg;
    typedef logic [15:0] sar_word_t;
    typedef logic [4:0] sar_cnt_t;
    typedef enum logic [1:0] {
        SAR_PH_SHUT,
        SAR_PH_ACQ,
        SAR_PH_CONV,
        SAR_PH_READ
    } sar_phase_e;
endpackage : sar_pkg

// ### logic/sar_strm_if.sv
// Valid/ready word stream between the block's modules
`timescale 1ns/10ps
`default_nettype none
interface sar_strm_if #(
    parameter int W = 16
);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : sar_strm_if
`default_nettype wire

// ### logic/sar_buf.sv
// Small flip-flop FIFO between result capture and the consumer
`timescale 1ns/10ps
`default_nettype none
module sar_buf #(
    parameter int W = 16,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Streams
    sar_strm_if.snk up,
    sar_strm_if.src dn
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("sar_buf: DEPTH must be a power of two, at least 2");
    end

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign up.ready = (cnt_q != (AW+1)'(DEPTH));
    assign dn.valid = (cnt_q != '0);
    assign dn.data = mem_q[rd_q];
    assign push = up.valid && up.ready;
    assign pop = dn.valid && dn.ready;

    // --------------------------------------------------------------
    // Storage
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= up.data;
        end
    end

    // --------------------------------------------------------------
    // Pointers and fill level
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= rd_q + AW'(1);
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + (AW+1)'(1);
            end else if (pop && !push) begin
                cnt_q <= cnt_q - (AW+1)'(1);
            end
        end
    end
endmodule : sar_buf
`default_nettype wire

// ### logic/sar_readout.sv
// Digital side of a serial-readout successive-approximation converter
//
// Operation
// - Chip select high keeps shutdown; chip select low powers the core.
// - Chip select falling starts a fresh acquisition and conversion.
// - Serial clock alone times conversion and output, at most 4.8MHz.
// - Serial output changes only on serial clock falling edges.
// - Serial output is released whenever chip select is high.
// - Frame sends eight zeros, then the 14-bit result MSB first.
// - Result is an unsigned code, zero at ground, full at reference.
// - Track from chip select fall until falling edge six, then hold.
// - Edges 7 to 22 run the approximation, one bit resolved per step.
// - A frame is 24 falling edges: zeros, result, two sub-bits.
// - Extra edges after the sub-bits give zeros and change nothing.
// - Chip select rising mid-conversion aborts at once into shutdown.
`include "sar_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module sar_readout #(
    parameter int ACQ_CYC = `SAR_ACQ_CYC,
    parameter int CSW_CYC = `SAR_CSW_CYC,
    parameter int TCP_CYC = `SAR_TCP_CYC,
    parameter int BUF_DEPTH = 2
) (
    // System clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Serial link
    input wire logic ser_clk,
    input wire logic chip_sel_n,
    output logic ser_data_o,
    output logic ser_data_oe,
    // Converter core
    input wire logic cmp_above,
    output logic pwr_on,
    output logic analog_track,
    output sar_pkg::sar_word_t sar_dac_code,
    // Result stream
    output logic res_valid,
    input wire logic res_ready,
    output logic [`SAR_RES_BITS-1:0] res_code,
    output logic [`SAR_SUB_BITS-1:0] res_sub,
    // Status
    output var sar_pkg::sar_phase_e phase,
    output logic aborted,
    output logic acq_short,
    output logic csw_short,
    output logic rate_err,
    output logic overrun
);
    import sar_pkg::*;

    if (ACQ_CYC < 1 || ACQ_CYC > 255) begin : g_chk_acq
        $error("sar_readout: ACQ_CYC out of range 1..255");
    end
    if (CSW_CYC < 1 || CSW_CYC > 255) begin : g_chk_csw
        $error("sar_readout: CSW_CYC out of range 1..255");
    end
    if (TCP_CYC < 1 || TCP_CYC > 127) begin : g_chk_tcp
        $error("sar_readout: TCP_CYC out of range 1..127");
    end

    localparam logic [7:0] ACQ_LIM = 8'(ACQ_CYC);
    localparam logic [7:0] CSW_LIM = 8'(CSW_CYC);
    localparam logic [7:0] PER_LIM = 8'(2 * TCP_CYC);
    localparam logic [7:0] CNT_TOP = 8'hFF;

    // --------------------------------------------------------------
    // Link domain: falling edge of the serial clock
    // --------------------------------------------------------------
    sar_cnt_t edge_cnt_q;
    sar_cnt_t edge_n;
    sar_word_t sar_q;
    sar_word_t sar_d;
    logic [3:0] bit_p;
    logic [3:0] out_p;
    logic dout_q;
    logic dout_d;
    logic done_q;
    logic edge_tgl_q;
    logic smp_lvl;

    // Counter stops at the frame length so later edges are inert
    assign edge_n = (edge_cnt_q == `SAR_FRAME_EDGES) ?
        edge_cnt_q : edge_cnt_q + 5'h01;
    assign bit_p = 4'(`SAR_LAST_STEP - edge_n);
    assign out_p = 4'(`SAR_LAST_OUT - edge_n);
    assign smp_lvl = (edge_cnt_q >= `SAR_SAMPLE_EDGE);

    always_ff @(negedge ser_clk or posedge chip_sel_n) begin
        if (chip_sel_n) begin
            edge_cnt_q <= '0;
        end else begin
            edge_cnt_q <= edge_n;
        end
    end

    // Trial code: load MSB trial at sampling, then one bit per edge
    always_comb begin
        sar_d = sar_q;
        if (edge_n == `SAR_SAMPLE_EDGE) begin
            sar_d = `SAR_TRIAL_MSB;
        end else if (edge_n >= `SAR_FIRST_STEP &&
                     edge_n <= `SAR_LAST_STEP) begin
            sar_d[bit_p] = cmp_above;
            if (bit_p != 4'h0) begin
                sar_d[bit_p - 4'h1] = 1'b1;
            end
        end
    end

    always_ff @(negedge ser_clk or posedge chip_sel_n) begin
        if (chip_sel_n) begin
            sar_q <= `SAR_WORD_RST;
        end else begin
            sar_q <= sar_d;
        end
    end

    // Leading zeros, then result and sub-bits, then trailing zeros
    always_comb begin
        dout_d = 1'b0;
        if (edge_n >= `SAR_FIRST_OUT && edge_n <= `SAR_LAST_OUT) begin
            dout_d = sar_q[out_p];
        end
    end

    always_ff @(negedge ser_clk or posedge chip_sel_n) begin
        if (chip_sel_n) begin
            dout_q <= 1'b0;
        end else begin
            dout_q <= dout_d;
        end
    end

    // Conversion-complete level, dropped by chip select rising
    always_ff @(negedge ser_clk or posedge chip_sel_n) begin
        if (chip_sel_n) begin
            done_q <= 1'b0;
        end else if (edge_n == `SAR_LAST_STEP) begin
            done_q <= 1'b1;
        end
    end

    // Edge toggle for clock-rate supervision
    always_ff @(negedge ser_clk or posedge chip_sel_n) begin
        if (chip_sel_n) begin
            edge_tgl_q <= 1'b0;
        end else begin
            edge_tgl_q <= ~edge_tgl_q;
        end
    end

    // --------------------------------------------------------------
    // Pins and converter core controls
    // --------------------------------------------------------------
    assign pwr_on = ~chip_sel_n;
    assign ser_data_oe = ~chip_sel_n;
    assign ser_data_o = dout_q;
    assign analog_track = ~chip_sel_n && !smp_lvl;
    assign sar_dac_code = sar_q;

    // --------------------------------------------------------------
    // Crossing into the system clock
    // --------------------------------------------------------------
    logic [3:0] pin_vec;
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic [3:0] s3_q;
    logic [3:0] st_q;
    logic [3:0] prev_q;
    logic [3:0] agree;
    logic [3:0] rise;
    logic cs_s;
    logic smp_s;
    logic done_rise;
    logic tgl_rise;

    assign pin_vec = {edge_tgl_q, done_q, smp_lvl, chip_sel_n};
    assign agree = ~(s2_q ^ s3_q);
    assign rise = st_q & ~prev_q;
    assign cs_s = st_q[0];
    assign smp_s = st_q[1];
    assign done_rise = rise[2];
    assign tgl_rise = rise[3];

    // A change counts once the second and third stages agree
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s1_q <= `SAR_SYNC_RST;
            s2_q <= `SAR_SYNC_RST;
            s3_q <= `SAR_SYNC_RST;
            st_q <= `SAR_SYNC_RST;
            prev_q <= `SAR_SYNC_RST;
        end else begin
            s1_q <= pin_vec;
            s2_q <= s1_q;
            s3_q <= s2_q;
            st_q <= (st_q & ~agree) | (s3_q & agree);
            prev_q <= st_q;
        end
    end

    // --------------------------------------------------------------
    // Frame phase tracking
    // --------------------------------------------------------------
    sar_phase_e phase_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            phase_q <= SAR_PH_SHUT;
        end else begin
            case (phase_q)
                SAR_PH_SHUT: begin
                    if (!cs_s) begin
                        phase_q <= SAR_PH_ACQ;
                    end
                end
                SAR_PH_ACQ: begin
                    if (cs_s) begin
                        phase_q <= SAR_PH_SHUT;
                    end else if (smp_s) begin
                        phase_q <= SAR_PH_CONV;
                    end
                end
                SAR_PH_CONV: begin
                    if (cs_s) begin
                        phase_q <= SAR_PH_SHUT;
                    end else if (done_rise) begin
                        phase_q <= SAR_PH_READ;
                    end
                end
                SAR_PH_READ: begin
                    if (cs_s) begin
                        phase_q <= SAR_PH_SHUT;
                    end
                end
                default: begin
                    phase_q <= SAR_PH_SHUT;
                end
            endcase
        end
    end

    assign phase = phase_q;

    // Abort pulse when chip select rises before completion
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            aborted <= 1'b0;
        end else begin
            aborted <= cs_s && (phase_q == SAR_PH_ACQ ||
                                phase_q == SAR_PH_CONV);
        end
    end

    // --------------------------------------------------------------
    // Host timing supervision
    // --------------------------------------------------------------
    logic [7:0] acq_cnt_q;
    logic [7:0] csw_cnt_q;
    logic [7:0] per_cnt_q;
    logic frame_start;

    assign frame_start = (phase_q == SAR_PH_SHUT) && !cs_s;

    // Acquisition time from chip select fall to the sampling edge
    always_ff @(posedge clk_sys) begin
        if (sys_rst || phase_q == SAR_PH_SHUT) begin
            acq_cnt_q <= '0;
        end else if (acq_cnt_q != CNT_TOP) begin
            acq_cnt_q <= acq_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst || frame_start) begin
            acq_short <= 1'b0;
        end else if (phase_q == SAR_PH_ACQ && smp_s &&
                     acq_cnt_q < ACQ_LIM) begin
            acq_short <= 1'b1;
        end
    end

    // Chip select high time; starts saturated after reset
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            csw_cnt_q <= CNT_TOP;
        end else if (phase_q != SAR_PH_SHUT) begin
            csw_cnt_q <= '0;
        end else if (csw_cnt_q != CNT_TOP) begin
            csw_cnt_q <= csw_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            csw_short <= 1'b0;
        end else if (frame_start) begin
            csw_short <= (csw_cnt_q < CSW_LIM);
        end
    end

    // Two serial clock periods between toggle rises
    always_ff @(posedge clk_sys) begin
        if (sys_rst || phase_q == SAR_PH_SHUT) begin
            per_cnt_q <= CNT_TOP;
        end else if (tgl_rise) begin
            per_cnt_q <= '0;
        end else if (per_cnt_q != CNT_TOP) begin
            per_cnt_q <= per_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst || frame_start) begin
            rate_err <= 1'b0;
        end else if (tgl_rise && per_cnt_q < PER_LIM) begin
            rate_err <= 1'b1;
        end
    end

    // --------------------------------------------------------------
    // Result capture into the output buffer
    // --------------------------------------------------------------
    sar_strm_if #(.W(`SAR_WORD_BITS)) cap_if ();
    sar_strm_if #(.W(`SAR_WORD_BITS)) out_if ();

    logic pend_v_q;
    sar_word_t pend_w_q;
    logic ovr;

    // Word is stable from the done level until chip select rises
    assign ovr = done_rise && pend_v_q && !cap_if.ready;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pend_v_q <= 1'b0;
        end else if (done_rise) begin
            pend_v_q <= 1'b1;
        end else if (cap_if.ready) begin
            pend_v_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pend_w_q <= `SAR_WORD_RST;
        end else if (done_rise && !ovr) begin
            pend_w_q <= sar_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            overrun <= 1'b0;
        end else begin
            overrun <= ovr;
        end
    end

    assign cap_if.valid = pend_v_q;
    assign cap_if.data = pend_w_q;

    sar_buf #(
        .W(`SAR_WORD_BITS),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .up(cap_if.snk),
        .dn(out_if.src)
    );

    assign res_valid = out_if.valid;
    assign out_if.ready = res_ready;
    assign res_code = out_if.data[`SAR_WORD_BITS-1:`SAR_SUB_BITS];
    assign res_sub = out_if.data[`SAR_SUB_BITS-1:0];
endmodule : sar_readout
`default_nettype wire

// ### dv/sar_readout_chk.sv
// Checker for the serial converter readout block
`include "sar_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module sar_readout_chk (
    // Clocks and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ser_clk,
    // Link and core
    input wire logic chip_sel_n,
    input wire logic ser_data_o,
    input wire logic ser_data_oe,
    input wire logic pwr_on,
    input wire logic analog_track,
    input wire sar_pkg::sar_word_t sar_dac_code,
    // Result stream and status
    input wire logic res_valid,
    input wire logic res_ready,
    input wire logic [`SAR_RES_BITS-1:0] res_code,
    input wire logic [`SAR_SUB_BITS-1:0] res_sub,
    input wire logic aborted
);
    import sar_pkg::*;
    // ------------------------------------------------------------
    // Falling-edge count within the frame, saturating
    // ------------------------------------------------------------
    sar_cnt_t edge_cnt_q;
    always_ff @(negedge ser_clk or posedge chip_sel_n) begin
        if (chip_sel_n) begin
            edge_cnt_q <= 5'h00;
        end else if (edge_cnt_q != 5'h1F) begin
            edge_cnt_q <= edge_cnt_q + 5'h01;
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    chk_power_and_enable: assert property (@(posedge clk_sys)
        disable iff (sys_rst) (ser_data_oe == !chip_sel_n)
        && (pwr_on == !chip_sel_n)) else $error("enable or power wrong");
    chk_shut_clears_all: assert property (@(posedge clk_sys)
        chip_sel_n |-> !ser_data_o && !analog_track
        && sar_dac_code == 16'h0000) else $error("state not cleared");
    chk_out_steady_high: assert property (@(posedge clk_sys)
        disable iff (chip_sel_n) ser_clk && $past(ser_clk)
        |-> $stable(ser_data_o)) else $error("output moved on high clock");
    chk_track_six_edges: assert property (@(posedge ser_clk)
        disable iff (chip_sel_n) analog_track == (edge_cnt_q < 5'h06))
        else $error("track window wrong");
    chk_lead_zeros: assert property (@(posedge ser_clk)
        disable iff (chip_sel_n) edge_cnt_q < 5'h08 |-> !ser_data_o)
        else $error("leading bit not zero");
    chk_trail_zeros: assert property (@(posedge ser_clk)
        disable iff (chip_sel_n) edge_cnt_q >= 5'h18 |-> !ser_data_o)
        else $error("trailing bit not zero");
    chk_code_frozen: assert property (@(posedge ser_clk)
        disable iff (chip_sel_n) edge_cnt_q >= 5'h17
        |-> $stable(sar_dac_code)) else $error("code moved after end");
    chk_abort_pulse: assert property (@(posedge clk_sys)
        disable iff (sys_rst) aborted |-> chip_sel_n ##1 !aborted)
        else $error("abort pulse wrong");
    chk_word_held: assert property (@(posedge clk_sys)
        disable iff (sys_rst) res_valid && !res_ready |=> res_valid
        && $stable(res_code) && $stable(res_sub))
        else $error("pending word changed");
endmodule : sar_readout_chk
bind sar_readout sar_readout_chk sar_readout_chk_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ser_clk(ser_clk),
    .chip_sel_n(chip_sel_n), .ser_data_o(ser_data_o),
    .ser_data_oe(ser_data_oe), .pwr_on(pwr_on),
    .analog_track(analog_track), .sar_dac_code(sar_dac_code),
    .res_valid(res_valid), .res_ready(res_ready), .res_code(res_code),
    .res_sub(res_sub), .aborted(aborted)
);
`default_nettype wire

// ### dv/sar_host_model.sv
// Host model: chip select, serial clock, capture and comparator
`timescale 1ns/10ps
`default_nettype none
module sar_host_model (
    // Serial link
    output logic ser_clk,
    output logic chip_sel_n,
    input wire logic ser_line,
    // Analog core stand-in
    input wire sar_pkg::sar_word_t sar_dac_code,
    output logic cmp_above
);
    import sar_pkg::*;
    logic [15:0] ain_q = 16'h0000;
    logic [31:0] cap_q = 32'h0000_0000;
    // Late rising chip select clears the link flops at start
    initial begin
        ser_clk = 1'b0;
        chip_sel_n = 1'b0;
        #1;
        chip_sel_n = 1'b1;
    end
    // Input at or above trial code
    assign cmp_above = (ain_q >= sar_dac_code);
    // Clock stands low outside frames
    task frame(input int n, input int pre, input int gap);
        #3.1;
        cap_q = 32'h0000_0000;
        chip_sel_n = 1'b0;
        #(pre);
        repeat (n) begin
            ser_clk = 1'b1;
            cap_q = {cap_q[30:0], ser_line};
            #40;
            ser_clk = 1'b0;
            #40;
        end
        chip_sel_n = 1'b1;
        #(gap);
    endtask : frame
endmodule : sar_host_model
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the serial converter readout block
`include "sar_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import sar_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic res_ready = 1'b0;
    logic line_q = 1'b0;
    logic ab_seen = 1'b0;
    logic ovr_seen = 1'b0;
    int n_fail = 0;
    int cmp_count = 0;
    wire logic ser_clk, chip_sel_n, ser_line, ser_data_o, ser_data_oe;
    wire logic cmp_above, pwr_on, analog_track, res_valid, aborted;
    wire logic acq_short, csw_short, rate_err, overrun;
    wire sar_word_t sar_dac_code;
    wire logic [`SAR_RES_BITS-1:0] res_code;
    wire logic [`SAR_SUB_BITS-1:0] res_sub;
    sar_phase_e phase;
    always #4 clk_sys = ~clk_sys;
    // Released line shows the inverse of its last value
    always @(posedge clk_sys) begin
        if (ser_data_oe === 1'b1) begin
            line_q <= ser_data_o;
        end
        if (aborted === 1'b1) begin
            ab_seen <= 1'b1;
        end
        if (overrun === 1'b1) begin
            ovr_seen <= 1'b1;
        end
    end
    assign ser_line = (ser_data_oe === 1'b1) ? ser_data_o : ~line_q;
    sar_readout sar_readout_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .ser_clk(ser_clk),
        .chip_sel_n(chip_sel_n), .ser_data_o(ser_data_o),
        .ser_data_oe(ser_data_oe), .cmp_above(cmp_above), .pwr_on(pwr_on),
        .analog_track(analog_track), .sar_dac_code(sar_dac_code),
        .res_valid(res_valid), .res_ready(res_ready), .res_code(res_code),
        .res_sub(res_sub), .phase(phase), .aborted(aborted),
        .acq_short(acq_short), .csw_short(csw_short),
        .rate_err(rate_err), .overrun(overrun)
    );
    sar_host_model sar_host_model_inst (
        .ser_clk(ser_clk), .chip_sel_n(chip_sel_n), .ser_line(ser_line),
        .sar_dac_code(sar_dac_code), .cmp_above(cmp_above)
    );
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task check(input string what, input logic [31:0] got,
               input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task results;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results
    task run_frame(input logic [15:0] analog_input, input int n, input int pre);
        sar_host_model_inst.ain_q = analog_input;
        sar_host_model_inst.frame(n, pre, 300);
        @(negedge clk_sys);
    endtask : run_frame
    task pop(input logic [15:0] v);
        int k;
        k = 0;
        while (res_valid !== 1'b1 && k < 10) begin
            @(negedge clk_sys);
            k++;
        end
        check("res_valid", 32'(res_valid), 32'h1);
        check("res_code", 32'(res_code), 32'(v[15:2]));
        check("res_sub", 32'(res_sub), 32'(v[1:0]));
        res_ready = 1'b1;
        @(negedge clk_sys);
        res_ready = 1'b0;
        @(negedge clk_sys);
    endtask : pop
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        check("phase", 32'(phase), 32'(SAR_PH_SHUT));
        check("oe", 32'(ser_data_oe), 32'h0);
        check("res_valid", 32'(res_valid), 32'h0);
    endtask : t_reset
    task t_frames;
        logic [15:0] vals [3];
        vals = '{16'h0000, 16'hFFFF, 16'hA5C3};
        foreach (vals[i]) begin
            run_frame(vals[i], 26, 1300);
            check("stream", sar_host_model_inst.cap_q,
                  {14'h0000, vals[i], 2'b00});
            check("acq_short", 32'(acq_short), 32'h0);
            // Bench link clock runs faster than the supervised limit
            check("rate_err", 32'(rate_err), 32'h1);
            check("csw_short", 32'(csw_short), 32'h0);
            pop(vals[i]);
            check("empty", 32'(res_valid), 32'h0);
        end
    endtask : t_frames
    task t_abort;
        run_frame(16'h1234, 12, 200);
        check("aborted", 32'(ab_seen), 32'h1);
        check("no word", 32'(res_valid), 32'h0);
        check("acq_short", 32'(acq_short), 32'h1);
        check("oe off", 32'(ser_data_oe), 32'h0);
    endtask : t_abort
    task t_overrun;
        logic [15:0] vals [4];
        vals = '{16'h1110, 16'h2224, 16'h333C, 16'h4448};
        foreach (vals[i]) begin
            run_frame(vals[i], 24, 1300);
        end
        check("overrun", 32'(ovr_seen), 32'h1);
        check("acq_short", 32'(acq_short), 32'h0);
        for (int i = 0; i < 3; i++) begin
            pop(vals[i]);
        end
        repeat (8) @(negedge clk_sys);
        check("drained", 32'(res_valid), 32'h0);
    endtask : t_overrun
    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (6) @(negedge clk_sys);
        t_reset;
        t_frames;
        t_abort;
        t_overrun;
        results;
    end
    initial begin
        #200000;
        n_fail++;
        results;
    end
endmodule : tb_top
`default_nettype wire
